// ===== rtl/fcc_core.sv
`timescale 1ns/100ps
// Overview of operation
// R01: A machine cycle lasts four clocks and instructions are sequenced in such cycles.
// R02: An external data move lasts a programmable two to nine machine cycles.
// R03: A 1KB data SRAM at 0000h-03ffh is reached only by the external data move.
// R04: Software selects whether the on-chip SRAM serves moves that fall in its range.
// R05: Opcode a5h decrements the active data pointer by one.
// R06: Two independent sixteen-bit data pointers are provided.
// R07: Port 4 is four bidirectional bits, bit 0 optionally a wait input.
// R08: Port 4 bit 3 optionally requests a restart from the loader flash bank.
// R09: Port 3 bits carry serial, interrupt, timer and data strobe functions.
// R10: With the SRAM enabled, addresses above 03ffh go to the port 0/2 bus.
// R11: After reset the SRAM is disabled and all moves go to the external bus; the core has no reset state for this and routes by sram_en_i.
// R12: An asserted enabled wait input holds the strobe and extends the access.
module fcc_core
   import fcc_pkg::*;
(
   input wire logic clk_i, // 40 MHz system clock.
   input wire logic sys_rst_i, // Synchronous active-high reset.
   input wire fcc_pkg::fcc_op_t op_i, // Instruction issue from the decoder.
   input wire logic sram_en_i, // Route low moves to on-chip SRAM.
   input wire logic [3:0] stretch_i, // Move length in machine cycles.
   input wire logic data_pointer_sel_i, // Active data pointer select.
   input wire logic wait_en_i, // Port 4 bit 0 acts as wait input.
   input wire logic reboot_en_i, // Port 4 bit 3 acts as restart input.
   input wire logic [7:0] p0_i, // Port 0 pin levels.
   input wire logic [7:0] p3_i, // Port 3 pin levels.
   input wire logic [3:0] p4_i, // Port 4 pin levels.
   input wire logic [7:0] p3_gpio_i, // Port 3 general output values.
   input wire logic [3:0] p4_gpio_i, // Port 4 general output values.
   input wire logic txd_i, // Serial port 0 transmit data.
   output logic [7:0] p0_o, // Port 0 output data.
   output logic [7:0] p0_oe_n_o, // Port 0 enables, low drives.
   output logic [7:0] p2_o, // Port 2 high address.
   output logic ale_o, // Address latch enable.
   output logic [7:0] p3_o, // Port 3 output data.
   output logic [7:0] p3_oe_n_o, // Port 3 enables, low drives.
   output logic [3:0] p4_o, // Port 4 output data.
   output logic [3:0] p4_oe_n_o, // Port 4 enables, low drives.
   output logic [4:0] p3_alt_o, // Rx, ext irq a/b, timer a/b inputs.
   output logic busy_o, // Instruction in progress.
   output logic done_o, // Instruction finished pulse.
   output logic [7:0] rdata_o, // Data read by a move.
   output logic [15:0] data_pointer_o, // Active data pointer.
   output logic mc_tick_o, // Machine cycle boundary pulse.
   output logic reboot_o // Restart from loader flash bank request, high while the pin is held low.
);
   import fcc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_MOVE = 4'b0100,
      ST_WAIT = 4'b1000
   } fcc_state_t;

   function automatic logic in_sram(input logic en, input logic [15:0] a);
      in_sram = en && (a <= SRAM_LAST); // [R04] [R10] [R11]
   endfunction : in_sram

   fcc_state_t state_r, state_nxt;
   logic [1:0] phase_r;
   logic [3:0] mc_cnt_r;
   logic [3:0] mc_len_r;
   logic is_wr_r, local_r;
   logic [7:0] wdata_r;
   logic [15:0] addr_r;
   logic [7:0] sram_r [SRAM_WORDS];
   logic [3:0] p4_s1_r, p4_s2_r;
   logic [7:0] p3_s1_r, p3_s2_r, p0_s1_r, p0_s2_r;
   logic [1:0] dreq;
   logic mc_end, wait_hold, is_move;
   logic [3:0] len_clip;
   logic [15:0] data_pointer_w;
   fcc_bus_t bus;
   logic rd_n, wr_n;

   fcc_data_pointer_bank u_data_pointer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sel_i(data_pointer_sel_i),
      .req_i(dreq),
      .load_i(op_i.operand),
      .ptr_o(data_pointer_w)
   );

   always_ff @(posedge clk_i)
   begin
      p0_s1_r <= p0_i;
      p0_s2_r <= p0_s1_r;
      p3_s1_r <= p3_i;
      p3_s2_r <= p3_s1_r;
      p4_s1_r <= p4_i;
      p4_s2_r <= p4_s1_r;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         phase_r <= 2'h0;
      else
         phase_r <= phase_r + 2'h1; // [R01]
   end

   assign mc_end = (phase_r == PH_LAST); // [R01]
   assign wait_hold = wait_en_i && p4_s2_r[P4_WAIT_BIT]; // [R07] [R12]
   assign is_move = (op_i.opcode == OP_MOVE_RD) || (op_i.opcode == OP_MOVE_WR);

   always_comb
   begin
      if (stretch_i < STRETCH_MIN)
         len_clip = STRETCH_MIN; // [R02]
      else if (stretch_i > STRETCH_MAX)
         len_clip = STRETCH_MAX;
      else
         len_clip = stretch_i;
   end

   always_comb
   begin
      dreq = 2'h0;
      if (state_r == ST_IDLE && op_i.valid && mc_end)
      begin
         case (op_i.opcode)
            OP_DATA_POINTER_DEC: dreq = REQ_DEC; // [R05]
            OP_DATA_POINTER_INC: dreq = REQ_INC;
            OP_DATA_POINTER_LOAD: dreq = REQ_LOAD;
            default: dreq = 2'h0;
         endcase
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (op_i.valid && mc_end)
               state_nxt = is_move ? ST_MOVE : ST_EXEC;
         ST_EXEC:
            if (mc_end)
               state_nxt = ST_IDLE; // [R01]
         ST_MOVE:
            if (mc_end && mc_cnt_r == mc_len_r - 4'h1)
               state_nxt = (!local_r && wait_hold) ? ST_WAIT : ST_IDLE;
         ST_WAIT:
            if (!wait_hold && mc_end)
               state_nxt = ST_IDLE; // [R12]
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mc_cnt_r <= 4'h0;
         mc_len_r <= STRETCH_MIN;
         is_wr_r <= 1'b0;
         local_r <= 1'b0;
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
      end
      else if (state_r == ST_IDLE && op_i.valid && mc_end && is_move)
      begin
         mc_cnt_r <= 4'h0;
         mc_len_r <= len_clip; // [R02]
         is_wr_r <= (op_i.opcode == OP_MOVE_WR);
         local_r <= in_sram(sram_en_i, data_pointer_w); // [R03] [R04]
         addr_r <= data_pointer_w;
         wdata_r <= op_i.wdata;
      end
      else if (state_r == ST_MOVE && mc_end)
         mc_cnt_r <= mc_cnt_r + 4'h1;
   end

   // The on-chip array is written only here and read only by the move readback, so no internal addressing can touch it.
   always_ff @(posedge clk_i)
   begin
      if (state_r == ST_MOVE && local_r && is_wr_r && mc_cnt_r == 4'h0 && mc_end)
         sram_r[addr_r[SRAM_AW-1:0]] <= wdata_r; // [R03]
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         rdata_o <= 8'h00;
      else if (state_r != ST_IDLE && state_nxt == ST_IDLE && state_r != ST_EXEC && !is_wr_r)
         rdata_o <= local_r ? sram_r[addr_r[SRAM_AW-1:0]] : p0_s2_r; // [R10]
   end

   // Strobes drop in the cycle after the address latch and release only at the end, wait included.
   always_comb
   begin
      bus.addr_hi = 8'h00;
      bus.ad_out = 8'h00;
      bus.ad_oe_n = 1'b1;
      bus.ale = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      if ((state_r == ST_MOVE || state_r == ST_WAIT) && !local_r)
      begin
         bus.addr_hi = addr_r[15:8]; // [R10]
         if (state_r == ST_MOVE && mc_cnt_r == 4'h0 && phase_r == 2'h0)
         begin
            bus.ale = 1'b1;
            bus.ad_out = addr_r[7:0];
            bus.ad_oe_n = 1'b0;
         end
         else
         begin
            rd_n = is_wr_r; // [R09] [R12]
            wr_n = !is_wr_r;
            bus.ad_out = wdata_r;
            bus.ad_oe_n = !is_wr_r;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         p0_o <= 8'h00;
         p0_oe_n_o <= 8'hff;
         p2_o <= 8'h00;
         ale_o <= 1'b0;
         p3_o <= 8'hff;
         p3_oe_n_o <= 8'hff;
         p4_o <= 4'hf;
         p4_oe_n_o <= 4'hf;
         p3_alt_o <= 5'h1f;
      end
      else
      begin
         p0_o <= bus.ad_out;
         p0_oe_n_o <= {8{bus.ad_oe_n}};
         p2_o <= bus.addr_hi;
         ale_o <= bus.ale;
         p3_o <= {rd_n, wr_n, p3_gpio_i[5:2], txd_i, p3_gpio_i[0]}; // [R09]
         p3_oe_n_o <= {2'h0, p3_gpio_i[5:2], 1'b0, 1'b1}; // [R09]
         p3_alt_o <= {p3_s2_r[5], p3_s2_r[4], p3_s2_r[3], p3_s2_r[2], p3_s2_r[0]};
         p4_o <= p4_gpio_i; // [R07]
         // An enabled alternate input must never be driven, whatever its output value.
         p4_oe_n_o <= {p4_gpio_i[3] | reboot_en_i, p4_gpio_i[2:1],
                       p4_gpio_i[0] | wait_en_i};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         mc_tick_o <= 1'b0;
         reboot_o <= 1'b0;
         data_pointer_o <= 16'h0000;
      end
      else
      begin
         busy_o <= (state_nxt != ST_IDLE);
         done_o <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
         mc_tick_o <= mc_end; // [R01]
         reboot_o <= reboot_en_i && !p4_s2_r[P4_REBOOT_BIT]; // [R08]
         // Registered so the visible pointer never glitches while the select moves.
         data_pointer_o <= data_pointer_w; // [R06]
      end
   end
endmodule : fcc_core

// ===== rtl/fcc_pkg.sv
package fcc_pkg;
   localparam int CLKS_PER_MC = 4;
   localparam logic [1:0] PH_LAST = 2'h3;
   localparam logic [3:0] STRETCH_MIN = 4'h2;
   localparam logic [3:0] STRETCH_MAX = 4'h9;
   localparam logic [15:0] SRAM_LAST = 16'h03ff;
   localparam int SRAM_AW = 10;
   localparam int SRAM_WORDS = 1024;
   localparam logic [7:0] OP_DATA_POINTER_DEC = 8'ha5;
   localparam logic [7:0] OP_DATA_POINTER_INC = 8'ha3;
   localparam logic [7:0] OP_DATA_POINTER_LOAD = 8'h90;
   localparam logic [7:0] OP_MOVE_RD = 8'he0;
   localparam logic [7:0] OP_MOVE_WR = 8'hf0;
   localparam int P3_WR_BIT = 6;
   localparam int P3_RD_BIT = 7;
   localparam int P4_WAIT_BIT = 0;
   localparam int P4_REBOOT_BIT = 3;
   localparam logic [1:0] REQ_DEC = 2'h1;
   localparam logic [1:0] REQ_INC = 2'h2;
   localparam logic [1:0] REQ_LOAD = 2'h3;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [15:0] operand;
      logic [7:0] wdata;
   } fcc_op_t;

   typedef struct packed {
      logic [7:0] addr_hi;
      logic [7:0] ad_out;
      logic ad_oe_n;
      logic ale;
   } fcc_bus_t;
endpackage : fcc_pkg

// ===== rtl/fcc_data_pointer_bank.sv
`timescale 1ns/100ps
module fcc_data_pointer_bank
   import fcc_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic sys_rst_i, // Synchronous reset.
   input wire logic sel_i, // Active pointer select.
   input wire logic [1:0] req_i, // Pointer operation request.
   input wire logic [15:0] load_i, // Load value.
   output logic [15:0] ptr_o // Active pointer value.
);
   logic [15:0] ptr_r [2];

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ptr_r[0] <= 16'h0000; // [R06]
         ptr_r[1] <= 16'h0000;
      end
      else
      begin
         case (req_i)
            REQ_DEC: ptr_r[sel_i] <= ptr_r[sel_i] - 16'h0001; // [R05]
            REQ_INC: ptr_r[sel_i] <= ptr_r[sel_i] + 16'h0001;
            REQ_LOAD: ptr_r[sel_i] <= load_i;
            default: ;
         endcase
      end
   end

   assign ptr_o = ptr_r[sel_i];
endmodule : fcc_data_pointer_bank

// ===== test/fcc_core_asserts.sv
`timescale 1ns/100ps
module fcc_core_chk
   import fcc_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic sys_rst_i, // Reset.
   input wire logic sram_en_i, // On-chip SRAM select.
   input wire logic wait_en_i, // Wait input enable.
   input wire logic reboot_en_i, // Restart input enable.
   input wire logic [3:0] p4_i, // Port 4 pins.
   input wire logic [7:0] p0_o, // Low address.
   input wire logic [7:0] p2_o, // High address.
   input wire logic ale_o, // Address latch.
   input wire logic [7:0] p3_o, // Port 3 outputs.
   input wire logic mc_tick_o, // Machine cycle pulse.
   input wire logic reboot_o // Restart request level.
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [5:0] low_r;
   always_ff @(posedge clk_i)
      low_r <= (sys_rst_i || p3_o[7:6] == 2'h3) ? 6'h0 : low_r + 6'h1;
   sequence s_gap; !mc_tick_o [*3] ##1 mc_tick_o; endsequence
   sequence s_held; (!p3_o[7] && wait_en_i && p4_i[0]) [*6]; endsequence
   sequence s_rb; (reboot_en_i && !p4_i[3]) [*4]; endsequence
   property p_mc; mc_tick_o |=> s_gap; endproperty
   property p_min; $fell(p3_o[7]) |-> !p3_o[7] [*7]; endproperty
   property p_max; !wait_en_i |-> low_r <= 6'h23; endproperty
   property p_excl; p3_o[7] || p3_o[6]; endproperty
   property p_ale; ale_o |=> p3_o[7:6] != 2'h3; endproperty
   property p_route; ale_o && sram_en_i |-> {p2_o, p0_o} > SRAM_LAST; endproperty
   property p_wait; s_held |=> !p3_o[7]; endproperty
   property p_rb; s_rb |=> reboot_o; endproperty
   property p_rb_off; p4_i[3] |-> ##3 !reboot_o; endproperty
   property p_rb_en; !reboot_en_i |=> !reboot_o; endproperty
   a_mc: assert property (p_mc) else $error("bad machine cycle");
   a_min: assert property (p_min) else $error("move too short");
   a_max: assert property (p_max) else $error("move too long");
   a_excl: assert property (p_excl) else $error("both strobes low");
   a_ale: assert property (p_ale) else $error("no strobe after latch");
   a_route: assert property (p_route) else $error("SRAM range on bus");
   a_wait: assert property (p_wait) else $error("wait ignored");
   a_rb: assert property (p_rb) else $error("restart missed");
   a_rb_off: assert property (p_rb_off) else $error("spurious restart");
   a_rb_en: assert property (p_rb_en) else $error("restart while disabled");
endmodule : fcc_core_chk
bind fcc_core fcc_core_chk u_fcc_core_chk (.clk_i, .sys_rst_i, .sram_en_i, .wait_en_i,
   .reboot_en_i, .p4_i, .p0_o, .p2_o, .ale_o, .p3_o, .mc_tick_o, .reboot_o);

// ===== test/fcc_ext_mem.sv
`timescale 1ns/100ps
module fcc_ext_mem
   import fcc_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire fcc_pkg::fcc_bus_t bus_i, // Address and data bus.
   input wire logic rd_n_i, // Read strobe.
   input wire logic wr_n_i, // Write strobe.
   input wire logic [5:0] wait_len_i, // Wait cycles per access.
   output logic [7:0] ad_o, // Read data.
   output logic wait_o // Wait request.
);
   logic [7:0] mem [0:65535];
   logic [15:0] addr_r;
   logic [7:0] last_r = 8'h00;
   logic [5:0] wcnt_r = 6'h0;
   logic idle_r = 1'b1;
   always_ff @(posedge clk_i)
   begin
      if (bus_i.ale) addr_r <= {bus_i.addr_hi, bus_i.ad_out};
      if (!wr_n_i) mem[addr_r] <= bus_i.ad_out;
      last_r <= ad_o;
      idle_r <= rd_n_i & wr_n_i;
      wcnt_r <= (idle_r && !(rd_n_i & wr_n_i)) ? wait_len_i : wcnt_r - 6'(wcnt_r != 6'h0);
   end
   // A released bus toggles so that a read sampled too late cannot match.
   assign ad_o = rd_n_i ? ~last_r : mem[addr_r];
   assign wait_o = wcnt_r != 6'h0;
endmodule : fcc_ext_mem

// ===== test/fcc_core_bench.sv
`timescale 1ns/100ps
module fcc_core_bench;
   import fcc_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   fcc_op_t op_i = '0;
   logic sram_en_i = 1'b0, data_pointer_sel_i = 1'b0, wait_en_i = 1'b0, reboot_en_i = 1'b0;
   logic rb_n = 1'b1, txd_i = 1'b1, ale_o, busy_o, done_o, mc_tick_o, reboot_o, wt;
   logic [3:0] stretch_i = 4'h2;
   logic [5:0] alt = 6'h3f, wlen = 6'h0;
   logic [7:0] md, p0_o, p0_oe_n_o, p2_o, p3_o, rdata_o;
   logic [4:0] p3_alt_o;
   logic [7:0] gp3 = 8'hff, p3_oe_n_o;
   logic [3:0] gp4 = 4'hf, p4_o, p4_oe_n_o;
   logic [15:0] data_pointer_o;
   logic [31:0] seed = 32'h8855;
   int bad_count = 0, total_checks = 0, low;
   wire logic [7:0] p0_i = &p0_oe_n_o ? md : p0_o;
   wire logic [7:0] p3_i = {p3_o[7:6], alt};
   wire logic [3:0] p4_i = {rb_n, 2'h3, wt};
   always #12.5 clk_i = ~clk_i;
   fcc_core u_fcc_core (.clk_i, .sys_rst_i, .op_i, .sram_en_i, .stretch_i, .data_pointer_sel_i,
      .wait_en_i, .reboot_en_i, .p0_i, .p3_i, .p4_i, .p3_gpio_i(gp3), .p4_gpio_i(gp4),
      .txd_i, .p0_o, .p0_oe_n_o, .p2_o, .ale_o, .p3_o, .p3_oe_n_o, .p4_o, .p4_oe_n_o,
      .p3_alt_o, .busy_o, .done_o, .rdata_o, .data_pointer_o, .mc_tick_o, .reboot_o);
   fcc_ext_mem u_fcc_ext_mem (.clk_i, .bus_i(fcc_bus_t'{p2_o, p0_o, p0_oe_n_o[0], ale_o}),
      .rd_n_i(p3_o[7]), .wr_n_i(p3_o[6]), .wait_len_i(wlen), .ad_o(md), .wait_o(wt));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [3:0] clip(input logic [3:0] s);
      return s < STRETCH_MIN ? STRETCH_MIN : (s > STRETCH_MAX ? STRETCH_MAX : s);
   endfunction : clip
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      if (bad_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   // Entered at a rising edge; counts strobe-low cycles of the operation in low.
   task automatic run(input logic [7:0] opc, input logic [15:0] opd, input logic [7:0] wd);
      int n;
      n = 0;
      low = 0;
      op_i <= '{1'b1, opc, opd, wd};
      do @(negedge clk_i); while (busy_o !== 1'b1 && ++n < 50);
      @(posedge clk_i) op_i.valid <= 1'b0;
      while (done_o !== 1'b1 && ++n < 400)
      begin
         @(negedge clk_i);
         if (p3_o[7:6] !== 2'h3) low++;
      end
      chk(done_o, 1'b1);
      @(posedge clk_i);
   endtask : run
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
      run(OP_DATA_POINTER_LOAD, a, 8'h0);
      run(wr ? OP_MOVE_WR : OP_MOVE_RD, 16'h0, d);
   endtask : xfer
   initial
   begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      low = 0;
      // The first machine cycle after release carries no tick, so skip it.
      repeat (4) @(negedge clk_i);
      repeat (40) @(negedge clk_i) low += mc_tick_o;
      chk(low, 10);
      @(posedge clk_i);
      run(OP_DATA_POINTER_LOAD, 16'h0, 8'h0);
      run(OP_DATA_POINTER_DEC, 16'h0, 8'h0);
      chk(data_pointer_o, 16'hffff);
      seed = lfsr(seed);
      data_pointer_sel_i <= 1'b1;
      run(OP_DATA_POINTER_LOAD, seed[15:0], 8'h0);
      run(OP_DATA_POINTER_INC, 16'h0, 8'h0);
      chk(data_pointer_o, 16'(seed[15:0] + 16'h1));
      data_pointer_sel_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk(data_pointer_o, 16'hffff);
      @(posedge clk_i);
      for (int k = 0; k < 16; k++)
      begin
         seed = lfsr(seed);
         stretch_i <= k[3:0];
         xfer(1'b1, seed[15:0], seed[23:16]);
         chk(low, clip(k[3:0]) * 4 - 1);
         xfer(1'b0, seed[15:0], 8'h0);
         chk(rdata_o, seed[23:16]);
      end
      stretch_i <= 4'h2;
      xfer(1'b1, 16'h03ff, 8'h5a);
      sram_en_i <= 1'b1;
      xfer(1'b1, 16'h03ff, 8'ha6);
      chk(low, 0);
      xfer(1'b1, 16'h0400, 8'h3c);
      xfer(1'b0, 16'h03ff, 8'h0);
      chk(rdata_o, 8'ha6);
      sram_en_i <= 1'b0;
      xfer(1'b0, 16'h03ff, 8'h0);
      chk(rdata_o, 8'h5a);
      xfer(1'b0, 16'h0400, 8'h0);
      chk(rdata_o, 8'h3c);
      wait_en_i <= 1'b1;
      wlen <= 6'h0a;
      xfer(1'b1, 16'h1234, 8'h77);
      chk(low > 7 && (low + 1) % 4 == 0, 1);
      xfer(1'b0, 16'h1234, 8'h0);
      chk(rdata_o, 8'h77);
      wait_en_i <= 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         alt <= seed[5:0];
         txd_i <= seed[6];
         gp3 <= seed[15:8];
         gp4 <= seed[19:16];
         repeat (4) @(negedge clk_i);
         chk(p3_alt_o, {alt[5:2], alt[0]});
         chk(p3_o[1], txd_i);
         chk(p3_oe_n_o, {2'h0, gp3[5:2], 2'h1});
         chk({p4_o, p4_oe_n_o}, {gp4, gp4[3] | reboot_en_i, gp4[2:1], gp4[0] | wait_en_i});
         @(posedge clk_i);
      end
      for (int k = 0; k < 3; k++)
      begin
         reboot_en_i <= k != 2;
         rb_n <= k == 1;
         repeat (6) @(negedge clk_i);
         chk(reboot_o, k == 0);
         @(posedge clk_i);
      end
      // A reset in the middle of a read must abandon it and leave the bus idle.
      op_i <= '{1'b1, OP_MOVE_RD, 16'h0, 8'h0};
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b1;
      op_i.valid <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk({busy_o, done_o, ale_o, p3_o, p0_oe_n_o, p4_oe_n_o}, {3'h0, 8'hff, 8'hff, 4'hf});
      chk(data_pointer_o, 16'h0000);
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      xfer(1'b0, 16'h0400, 8'h0);
      chk(rdata_o, 8'h3c);
      results();
   end
   // The tests need about 1550 cycles; this allows over twenty times that.
   initial
   begin
      #1000000;
      bad_count++;
      results();
   end
endmodule : fcc_core_bench
